/* File: rtl/chg_det_defines.svh */
// bit positions and reset values of the charger detect control register
`ifndef CHG_DET_DEFINES_SVH
`define CHG_DET_DEFINES_SVH

`define CHG_REG_WIDTH 8
`define CHG_BIT_OVERRIDE 0
`define CHG_BIT_DET_COMPLETE 1
`define CHG_BIT_RISE_EN 2
`define CHG_BIT_FALL_EN 3
`define CHG_BIT_PULLUP_EN 4
`define CHG_BIT_CHG_FLAG 7
`define CHG_RST_PULLUP_EN 1'b0
`define CHG_RST_RISE_EN 1'b0
`define CHG_RST_FALL_EN 1'b0
`define CHG_RST_OVERRIDE 1'b0
`define CHG_RST_MANUAL_FLAG 1'b0
`define CHG_SYNC_STAGES 2

`endif

/* File: rtl/chg_det_pkg.sv */
// types shared by the charger detect control block
package chg_det_pkg;

   // analog comparator and detector levels, asynchronous to core_clk_in
   typedef struct packed {
      logic bvalid;
      logic vbus_a_sess_valid;
      logic auto_detect_done;
      logic auto_charger_found;
   } analog_status_s;

   // request toward the rxcmd sender of the ulpi port
   typedef struct packed {
      logic valid;
      logic alt_int;
   } rxcmd_req_s;

   typedef logic [7:0] reg_byte_t;

endpackage : chg_det_pkg

/* File: rtl/level_sync.sv */
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
   parameter int WIDTH = 4
) (
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule : level_sync

`default_nettype wire

/* File: rtl/charger_detect_bvalid_ctrl.sv */
// charger detect, dp weak pull-up and bvalid edge report control
//
// Behaviour
// - Outside uart mode, with the pull-up enable clear the dp weak pull-up is off, and when set it is on only while vbus is above a-session-valid.
// - With the fall enable set, each high-to-low bvalid change requests an rxcmd with alt_int set.
// - With the rise enable set, each low-to-high bvalid change requests an rxcmd with alt_int set.
// - Both bvalid edge enables reset to disabled, so no bvalid edge requests an rxcmd until one of them is written set.
// - The detection complete bit reads 1 once automatic detection has finished and 0 otherwise.
// - With override clear the charger present pin follows automatic detection, with it set it follows the written flag.
// - With override clear the charger flag is read only and shows the automatic detection result.
// - With override set the charger flag is writable and drives the charger present pin low or high.
// - In uart mode the dp weak pull-up is on regardless of the enable bit.
`timescale 1ns/1ps
`default_nettype none

`include "chg_det_defines.svh"

module charger_detect_bvalid_ctrl (
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire logic soft_reset_in,
   input wire logic uart_mode_in,
   input wire logic reg_wr_en_in,
   input wire chg_det_pkg::reg_byte_t reg_wr_data_in,
   input wire chg_det_pkg::analog_status_s analog_in,
   input wire logic rxcmd_ack_in,
   output chg_det_pkg::reg_byte_t reg_rd_data_out,
   output chg_det_pkg::rxcmd_req_s rxcmd_req_out,
   output logic dp_weak_pullup_out,
   output logic charger_present_out
);
   import chg_det_pkg::*;

   // pending rxcmd report toward the link
   typedef enum logic {REP_IDLE, REP_PENDING} report_state_e;

   analog_status_s status_sync;
   logic bvalid_prev;
   logic dp_weak_pullup_enable;
   logic rise_report_enable;
   logic fall_report_enable;
   logic manual_charger_override;
   logic manual_flag;
   logic charger_detected_flag;
   logic bvalid_rise;
   logic bvalid_fall;
   logic report_event;
   report_state_e rep_state;
   report_state_e next_rep_state;
   reg_byte_t next_rd_data;

   // pin levels pass two flops before any use
   level_sync #(
      .WIDTH($bits(analog_status_s))
   ) u_status_sync (
      .core_clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .async_in(analog_in),
      .sync_out(status_sync)
   );

   // edge memory of synchronised bvalid
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         bvalid_prev <= 1'b0;
      end else begin
         bvalid_prev <= status_sync.bvalid;
      end
   end

   // one-cycle edge of a level against its previous sample
   function automatic logic level_edge(input logic now_lvl, input logic prev_lvl, input logic rising);
      if (rising) begin
         return now_lvl & ~prev_lvl;
      end
      return ~now_lvl & prev_lvl;
   endfunction : level_edge

   assign bvalid_rise = level_edge(status_sync.bvalid, bvalid_prev, 1'b1);
   assign bvalid_fall = level_edge(status_sync.bvalid, bvalid_prev, 1'b0);

   // pull-up enable, cleared by soft reset
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         dp_weak_pullup_enable <= `CHG_RST_PULLUP_EN;
      end else if (soft_reset_in) begin
         dp_weak_pullup_enable <= `CHG_RST_PULLUP_EN;
      end else if (reg_wr_en_in) begin
         dp_weak_pullup_enable <= reg_wr_data_in[`CHG_BIT_PULLUP_EN];
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rise_report_enable <= `CHG_RST_RISE_EN;
      end else if (soft_reset_in) begin
         rise_report_enable <= `CHG_RST_RISE_EN;
      end else if (reg_wr_en_in) begin
         rise_report_enable <= reg_wr_data_in[`CHG_BIT_RISE_EN];
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         fall_report_enable <= `CHG_RST_FALL_EN;
      end else if (soft_reset_in) begin
         fall_report_enable <= `CHG_RST_FALL_EN;
      end else if (reg_wr_en_in) begin
         fall_report_enable <= reg_wr_data_in[`CHG_BIT_FALL_EN];
      end
   end

   // override; soft reset spares bit 7
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         manual_charger_override <= `CHG_RST_OVERRIDE;
      end else if (soft_reset_in) begin
         manual_charger_override <= `CHG_RST_OVERRIDE;
      end else if (reg_wr_en_in) begin
         manual_charger_override <= reg_wr_data_in[`CHG_BIT_OVERRIDE];
      end
   end

   // manual flag, not cleared by soft reset but reloaded from the auto result once override clears
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         manual_flag <= `CHG_RST_MANUAL_FLAG;
      end else if (!manual_charger_override) begin
         manual_flag <= status_sync.auto_charger_found;
      end else if (reg_wr_en_in) begin
         // writable only once override already set
         manual_flag <= reg_wr_data_in[`CHG_BIT_CHG_FLAG];
      end
   end

   assign charger_detected_flag = manual_charger_override ? manual_flag : status_sync.auto_charger_found;

   assign report_event = (rise_report_enable & bvalid_rise) | (fall_report_enable & bvalid_fall);
   // report state: new edge wins over acknowledge
   always_comb begin
      next_rep_state = rep_state;
      case (rep_state)
         REP_IDLE: begin
            if (report_event) begin
               next_rep_state = REP_PENDING;
            end
         end
         REP_PENDING: begin
            if (rxcmd_ack_in && !report_event) begin
               next_rep_state = REP_IDLE;
            end
         end
         default: begin
            next_rep_state = REP_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rep_state <= REP_IDLE;
      end else begin
         rep_state <= next_rep_state;
      end
   end

   // request level and alt_int straight from a flop
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rxcmd_req_out <= '0;
      end else begin
         rxcmd_req_out.valid <= (next_rep_state == REP_PENDING);
         rxcmd_req_out.alt_int <= (next_rep_state == REP_PENDING);
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         dp_weak_pullup_out <= 1'b0;
      end else if (uart_mode_in) begin
         dp_weak_pullup_out <= 1'b1;
      end else begin
         dp_weak_pullup_out <= dp_weak_pullup_enable & status_sync.vbus_a_sess_valid;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         charger_present_out <= 1'b0;
      end else begin
         charger_present_out <= charger_detected_flag;
      end
   end

   always_comb begin
      next_rd_data = '0;
      next_rd_data[`CHG_BIT_CHG_FLAG] = charger_detected_flag;
      next_rd_data[`CHG_BIT_PULLUP_EN] = dp_weak_pullup_enable;
      next_rd_data[`CHG_BIT_FALL_EN] = fall_report_enable;
      next_rd_data[`CHG_BIT_RISE_EN] = rise_report_enable;
      next_rd_data[`CHG_BIT_DET_COMPLETE] = status_sync.auto_detect_done;
      next_rd_data[`CHG_BIT_OVERRIDE] = manual_charger_override;
   end

   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         reg_rd_data_out <= '0;
      end else begin
         reg_rd_data_out <= next_rd_data;
      end
   end

endmodule : charger_detect_bvalid_ctrl

`default_nettype wire

/* File: sim/chg_det_sva.sv */
// assertions on the charger detect block ports
`timescale 1ns/1ps
`default_nettype none
module chg_det_sva (
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire logic soft_reset_in,
   input wire logic reg_wr_en_in,
   input wire chg_det_pkg::reg_byte_t reg_wr_data_in,
   input wire logic uart_mode_in,
   input wire logic rxcmd_ack_in,
   input wire chg_det_pkg::analog_status_s analog_in,
   input wire chg_det_pkg::reg_byte_t reg_rd_data_out,
   input wire chg_det_pkg::rxcmd_req_s rxcmd_req_out,
   input wire logic dp_weak_pullup_out,
   input wire logic charger_present_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_rep;
      ##[3:5] rxcmd_req_out.valid && rxcmd_req_out.alt_int;
   endsequence
   // write of bit 7 while override already stood and stays set
   sequence s_manual_write;
      reg_wr_en_in && !soft_reset_in && reg_wr_data_in[0] && reg_rd_data_out[0] && !$past(reg_wr_en_in)
         && !$past(soft_reset_in);
   endsequence
   chk_rise_rep: assert property ($rose(analog_in.bvalid) && reg_rd_data_out[2] |-> s_rep)
      else $error("rise lost");
   chk_fall_rep: assert property ($fell(analog_in.bvalid) && reg_rd_data_out[3] |-> s_rep)
      else $error("fall lost");
   chk_req_hold: assert property (rxcmd_req_out.valid && !rxcmd_ack_in |=> rxcmd_req_out.valid)
      else $error("req dropped");
   chk_pu_off: assert property ((!reg_rd_data_out[4] && !uart_mode_in)[*3] |-> !dp_weak_pullup_out)
      else $error("pullup on");
   chk_pu_vbus: assert property (dp_weak_pullup_out && !$past(uart_mode_in)
      |-> $past(analog_in.vbus_a_sess_valid, 3)) else $error("pullup no vbus");
   chk_pu_uart: assert property (uart_mode_in |=> dp_weak_pullup_out)
      else $error("uart pullup off");
   chk_det_bit: assert property ($stable(analog_in.auto_detect_done)[*4]
      |-> reg_rd_data_out[1] == analog_in.auto_detect_done) else $error("det bit");
   chk_auto_pin: assert property ((!reg_rd_data_out[0] && $stable(analog_in.auto_charger_found))[*5]
      |-> charger_present_out == analog_in.auto_charger_found) else $error("auto pin");
   chk_man_pin: assert property (s_manual_write |-> ##2 charger_present_out == $past(reg_wr_data_in[7], 2))
      else $error("manual pin");
endmodule : chg_det_sva
`default_nettype wire

/* File: sim/rxcmd_sink.sv */
// link side model taking rxcmd requests after a set lag
`timescale 1ns/1ps
`default_nettype none
module rxcmd_sink (
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire chg_det_pkg::rxcmd_req_s req_in,
   input wire logic [3:0] lag_in,
   output logic ack_out
);
   logic [3:0] cnt;
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ack_out <= 1'b0;
         cnt <= 4'h0;
      end else begin
         ack_out <= req_in.valid && !ack_out && cnt >= lag_in;
         cnt <= (req_in.valid && !ack_out && cnt < lag_in) ? cnt + 4'h1 : 4'h0;
      end
   end
endmodule : rxcmd_sink
`default_nettype wire

/* File: sim/tb_top.sv */
// bench for the charger detect control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import chg_det_pkg::*;
   logic core_clk_in = 0, rst_b_in = 0, soft_reset_in = 0, uart_mode_in = 0, reg_wr_en_in = 0;
   logic rxcmd_ack_in, dp_weak_pullup_out, charger_present_out;
   logic [3:0] lag = 4'h0;
   reg_byte_t reg_wr_data_in = 8'h00, reg_rd_data_out;
   analog_status_s analog_in = 4'h0;
   rxcmd_req_s rxcmd_req_out;
   int num_errors = 0, total_checks = 0, i;
   always #2.5 core_clk_in = ~core_clk_in;
   charger_detect_bvalid_ctrl i_charger_detect_bvalid_ctrl (
      .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .soft_reset_in(soft_reset_in), .uart_mode_in(uart_mode_in),
      .reg_wr_en_in(reg_wr_en_in), .reg_wr_data_in(reg_wr_data_in), .analog_in(analog_in), .rxcmd_ack_in(rxcmd_ack_in),
      .reg_rd_data_out(reg_rd_data_out), .rxcmd_req_out(rxcmd_req_out), .dp_weak_pullup_out(dp_weak_pullup_out),
      .charger_present_out(charger_present_out));
   rxcmd_sink i_rxcmd_sink (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .req_in(rxcmd_req_out), .lag_in(lag),
      .ack_out(rxcmd_ack_in));
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask : tick
   task automatic wr(input reg_byte_t d);
      reg_wr_en_in = 1;
      reg_wr_data_in = d;
      tick(1);
      reg_wr_en_in = 0;
      tick(3);
   endtask : wr
   task automatic chk(input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic edge_rep(input logic lvl, input logic [3:0] l);
      lag = l;
      analog_in.bvalid = lvl;
      for (i = 0; i < 9 && rxcmd_req_out.valid !== 1'b1; i++) tick(1);
      chk(rxcmd_req_out, 8'h03);
      tick(9);
      chk(rxcmd_req_out.valid, 8'h00);
   endtask : edge_rep
   task automatic summarize;
      if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize
   initial begin
      #5000;
      num_errors++;
      summarize;
   end
   initial begin
      tick(4);
      rst_b_in = 1;
      tick(2);
      chk(reg_rd_data_out, 8'h00);
      wr(8'h10);
      chk(dp_weak_pullup_out, 8'h00);
      analog_in.vbus_a_sess_valid = 1;
      tick(4);
      chk(dp_weak_pullup_out, 8'h01);
      wr(8'h00);
      chk(dp_weak_pullup_out, 8'h00);
      uart_mode_in = 1;
      tick(2);
      chk(dp_weak_pullup_out, 8'h01);
      uart_mode_in = 0;
      wr(8'h0C);
      edge_rep(1, 0);
      edge_rep(0, 5);
      wr(8'h08);
      analog_in.bvalid = 1;
      tick(9);
      chk(rxcmd_req_out.valid, 8'h00);
      analog_in.auto_detect_done = 1;
      analog_in.auto_charger_found = 1;
      tick(4);
      chk({reg_rd_data_out, charger_present_out}, 9'h115);
      wr(8'h00);
      chk(reg_rd_data_out, 8'h82);
      wr(8'h01);
      chk({reg_rd_data_out, charger_present_out}, 9'h107);
      wr(8'h01);
      chk({reg_rd_data_out, charger_present_out}, 9'h006);
      wr(8'h81);
      chk({reg_rd_data_out, charger_present_out}, 9'h107);
      analog_in.auto_charger_found = 0;
      tick(4);
      chk(charger_present_out, 8'h01);
      soft_reset_in = 1;
      tick(1);
      soft_reset_in = 0;
      tick(3);
      chk({reg_rd_data_out, charger_present_out}, 9'h004);
      wr(8'h1D);
      rst_b_in = 0;
      tick(2);
      rst_b_in = 1;
      tick(4);
      chk({rxcmd_req_out, reg_rd_data_out, charger_present_out}, 11'h004);
      summarize;
   end
endmodule : tb_top
bind charger_detect_bvalid_ctrl chg_det_sva i_chg_det_sva (
   .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .soft_reset_in(soft_reset_in), .reg_wr_en_in(reg_wr_en_in),
   .reg_wr_data_in(reg_wr_data_in), .uart_mode_in(uart_mode_in), .rxcmd_ack_in(rxcmd_ack_in), .analog_in(analog_in),
   .reg_rd_data_out(reg_rd_data_out), .rxcmd_req_out(rxcmd_req_out), .dp_weak_pullup_out(dp_weak_pullup_out),
   .charger_present_out(charger_present_out));
`default_nettype wire
